/* step_pkg.sv */
// Shared constants for the stepping driver and its controller
package step_pkg;
    // ----------------------------------------------------------------
    // Excitation counter
    // ----------------------------------------------------------------
    // Finest step is 0.00288 deg; 7.2 deg is 2500 finest steps
    localparam int          POS_W         = 12;
    localparam logic [11:0] POS_CYCLE     = 12'h9c4;
    localparam logic [11:0] POS_HOME      = 12'h000;
    localparam int          DIAL_W        = 4;
    localparam logic [3:0]  DIAL_DEFAULT  = 4'h0;

    // ----------------------------------------------------------------
    // Timing (clock 200 MHz)
    // ----------------------------------------------------------------
    localparam int          CLK_MHZ       = 200;
    localparam int          AWOFF_WAIT_MS = 150;
    localparam int          PWRUP_WAIT_MS = 1400;
    localparam int          BRAKE_WAIT_MS = 2200;
    localparam longint      AWOFF_WAIT_CYC = longint'(AWOFF_WAIT_MS) * 1000 * CLK_MHZ;
    localparam longint      PWRUP_WAIT_CYC = longint'(PWRUP_WAIT_MS) * 1000 * CLK_MHZ;
    localparam longint      BRAKE_WAIT_CYC = longint'(BRAKE_WAIT_MS) * 1000 * CLK_MHZ;

    // ----------------------------------------------------------------
    // Controller registers (AHB-Lite word offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_MOVE      = 8'h04;
    localparam logic [7:0]  REG_STATUS    = 8'h08;
    localparam logic [7:0]  REG_PERIOD    = 8'h0c;
    // CTRL field positions
    localparam int          CTRL_AWOFF    = 0;
    localparam int          CTRL_SEL_B    = 1;
    localparam int          CTRL_BRK_REL  = 2;
    localparam int          CTRL_DUAL     = 3;
    localparam int          CTRL_BRAKE_M  = 4;
    localparam logic [31:0] PERIOD_RESET  = 32'h0000_0064;
endpackage

/* step_link_if.sv */
// Signal link between the pulse controller and the stepping driver
`timescale 1ns/1ps
`default_nettype none
interface step_link_if;
    logic step_pulse_in;   // Pulse (single mode) or clockwise pulse (dual)
    logic dir_ccw_in;      // Direction (single) or counter-clockwise pulse (dual)
    logic awoff;           // All windings off
    logic step_sel_b;      // Step angle select
    logic brake_release;   // Brake free
    logic excitation_home_flag;
    logic overheat_ok;     // High in normal operation, low after trip

    modport drv (input step_pulse_in, dir_ccw_in, awoff, step_sel_b, brake_release,
                 output excitation_home_flag, overheat_ok);
    modport ctl (output step_pulse_in, dir_ccw_in, awoff, step_sel_b, brake_release,
                 input excitation_home_flag, overheat_ok);
endinterface
`default_nettype wire

/* step_driver.sv */
// Stepping driver logic: pulse decode, excitation counter, home flag, overheat
//
// How it works
// - Windings-off active cuts phase current
// - Windings-off released restores phase current
// - Controller waits 150 ms before pulses
// - Select low uses dial A, high dial B
// - Controller changes select only at home, rest
// - External brake mode: release input frees brake
// - Brake-motor setting: controller holds brake release while moving
// - Home flag active when position is zero
// - Reset puts excitation at home
// - Home flag once per 7.2 degrees
// - Step jumping past home gives no flag
// - Controller ends moves after the MOVE pulse count, at any position
// - Overheat output low after trip, lamp on
// - Auto current off: trip cuts current, brake
// - Auto off disabled: trip only drops output
// - Overheat latched until power cycle
// - Controller waits 1.4 s or 2.2 s
// - Single mode: pulse fall steps per direction
// - Dual mode: each input's fall steps it
`timescale 1ns/1ps
`default_nettype none
module step_driver
    import step_pkg::*;
(
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // Link to controller
    step_link_if.drv               link,
    // Switches and sensors
    input  wire logic [DIAL_W-1:0] step_angle_dial_a,
    input  wire logic [DIAL_W-1:0] step_angle_dial_b,
    input  wire logic              dual_pulse_mode,
    input  wire logic              auto_current_off,
    input  wire logic              brake_external,
    input  wire logic              over_temp,
    // Power stage
    output logic                   phase_current_on,
    output logic                   brake_released,
    output logic [POS_W-1:0]       excitation_pos,
    output logic                   home_led,
    output logic                   overheat_led
);
    // ----------------------------------------------------------------
    // Step size lookup (finest units per step)
    // ----------------------------------------------------------------
    function automatic logic [POS_W-1:0] step_size(input logic [DIAL_W-1:0] d);
        case (d)
            4'h0: step_size = 12'h0fa;  // 0.72 deg
            4'h1: step_size = 12'h07d;
            4'h2: step_size = 12'h064;
            4'h3: step_size = 12'h03e;  // 0.18 deg rounds to 62.5 -> 62
            4'h4: step_size = 12'h032;
            4'h5: step_size = 12'h01f;
            4'h6: step_size = 12'h019;
            4'h7: step_size = 12'h00c;
            4'h8: step_size = 12'h00a;
            4'h9: step_size = 12'h006;
            4'ha: step_size = 12'h005;
            4'hb: step_size = 12'h003;
            4'hc: step_size = 12'h002;
            4'hd: step_size = 12'h002;
            4'he: step_size = 12'h001;
            default: step_size = 12'h001;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic             pulse_d_r;
    logic             dir_d_r;
    logic             oh_trip_r;
    logic [POS_W-1:0] pos_r;
    logic [POS_W-1:0] pos_nxt;

    // Falling edges of the pulse inputs
    wire pulse_fall = pulse_d_r & ~link.step_pulse_in;
    wire ccw_fall   = dir_d_r & ~link.dir_ccw_in;
    wire step_cw    = dual_pulse_mode ? pulse_fall : (pulse_fall & link.dir_ccw_in);
    wire step_ccw   = dual_pulse_mode ? ccw_fall   : (pulse_fall & ~link.dir_ccw_in);
    wire oh_stop    = oh_trip_r & auto_current_off;
    wire current_on = ~link.awoff & ~oh_stop;
    wire [POS_W-1:0] step = link.step_sel_b ? step_size(step_angle_dial_b)
                                            : step_size(step_angle_dial_a);
    wire [POS_W:0]   up   = {1'b0, pos_r} + {1'b0, step};
    wire [POS_W:0]   dn   = {1'b0, pos_r} + {1'b0, POS_CYCLE} - {1'b0, step};

    // Next position, wrapping modulo one electrical cycle
    always_comb begin
        pos_nxt = pos_r;
        if (current_on && step_cw && !step_ccw) begin
            pos_nxt = (up >= {1'b0, POS_CYCLE}) ? POS_W'(up - {1'b0, POS_CYCLE})
                                                : up[POS_W-1:0];
        end else if (current_on && step_ccw && !step_cw) begin
            pos_nxt = (dn >= {1'b0, POS_CYCLE}) ? POS_W'(dn - {1'b0, POS_CYCLE})
                                                : dn[POS_W-1:0];
        end
    end

    // Edge history, position and overheat latch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_d_r <= 1'b0;
            dir_d_r   <= 1'b0;
            pos_r     <= POS_HOME;
            oh_trip_r <= 1'b0;
        end else begin
            pulse_d_r <= link.step_pulse_in;
            dir_d_r   <= link.dir_ccw_in;
            pos_r     <= pos_nxt;
            if (over_temp) begin
                oh_trip_r <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign excitation_pos            = pos_r;
    assign link.excitation_home_flag = (pos_r == POS_HOME);
    assign home_led                  = (pos_r == POS_HOME);
    assign link.overheat_ok          = ~oh_trip_r;
    assign overheat_led              = oh_trip_r;
    assign phase_current_on          = current_on;
    assign brake_released            = (brake_external ? link.brake_release : current_on)
                                       & ~oh_stop;
endmodule
`default_nettype wire

/* step_controller.sv */
// Pulse controller: AHB-Lite registers driving the stepping driver link
//
// The implementer's own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module step_controller
    import step_pkg::*;
#(
    parameter longint AWOFF_WAIT = AWOFF_WAIT_CYC,
    parameter longint PWRUP_WAIT = PWRUP_WAIT_CYC,
    parameter longint BRAKE_WAIT = BRAKE_WAIT_CYC
)(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Link to driver
    step_link_if.ctl         link
);
    // Wait counts must be non-zero and fit the 32-bit counters
    if (AWOFF_WAIT < 1 || PWRUP_WAIT < 1 || BRAKE_WAIT < 1 || AWOFF_WAIT > 64'hffff_ffff ||
        PWRUP_WAIT > 64'hffff_ffff || BRAKE_WAIT > 64'hffff_ffff) begin : g_bad_wait
        $error("wait counts must lie between one and the counter range");
    end

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic [7:0]  rd_addr_r;
    logic [4:0]  ctrl_r;
    logic [31:0] period_r;
    logic [31:0] remain_r;
    logic        dir_r;
    logic [31:0] ph_cnt_r;
    logic        pulse_r;
    logic [31:0] wait_r;
    logic        awoff_d_r;
    logic [31:0] up_r;
    logic        move_go;

    wire         take   = hsel & hready & htrans[1];
    wire [31:0]  start_wait = ctrl_r[CTRL_BRAKE_M] ? 32'(BRAKE_WAIT) : 32'(PWRUP_WAIT);
    wire         pwr_hold = (up_r < start_wait);
    wire         busy   = (remain_r != 32'h0) | pulse_r;
    wire [31:0]  status = {28'h0, link.overheat_ok, link.excitation_home_flag,
                           (wait_r != 32'h0) | pwr_hold, busy};

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign move_go   = wr_pend_r & (wr_addr_r == REG_MOVE);
    assign hrdata    = (rd_addr_r == REG_CTRL)   ? {27'h0, ctrl_r} :
                       (rd_addr_r == REG_STATUS) ? status :
                       (rd_addr_r == REG_PERIOD) ? period_r :
                       (rd_addr_r == REG_MOVE)   ? remain_r : 32'h0;

    // Address phase capture and register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rd_addr_r <= 8'hff;
            ctrl_r    <= 5'h00;
            period_r  <= PERIOD_RESET;
        end else begin
            wr_pend_r <= take & hwrite;
            wr_addr_r <= haddr[7:0];
            rd_addr_r <= (take & ~hwrite) ? haddr[7:0] : rd_addr_r;
            if (wr_pend_r && wr_addr_r == REG_CTRL) begin
                // Select may change only at home and at rest
                ctrl_r[CTRL_AWOFF]   <= hwdata[CTRL_AWOFF];
                ctrl_r[CTRL_BRK_REL] <= hwdata[CTRL_BRK_REL];
                ctrl_r[CTRL_DUAL]    <= hwdata[CTRL_DUAL];
                ctrl_r[CTRL_BRAKE_M] <= hwdata[CTRL_BRAKE_M];
                if (!busy && link.excitation_home_flag)
                    ctrl_r[CTRL_SEL_B] <= hwdata[CTRL_SEL_B];
            end
            if (wr_pend_r && wr_addr_r == REG_PERIOD && hwdata > 32'h1)
                period_r <= hwdata;
        end
    end

    // ----------------------------------------------------------------
    // Pulse generator: MOVE bit 31 is direction, low bits the count
    // ----------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            remain_r  <= 32'h0;
            dir_r     <= 1'b0;
            ph_cnt_r  <= 32'h0;
            pulse_r   <= 1'b0;
            wait_r    <= 32'h0;
            up_r      <= 32'h0;
            awoff_d_r <= 1'b0;
        end else begin
            awoff_d_r <= ctrl_r[CTRL_AWOFF];
            // Time since reset; a brake-motor setting made late still extends the hold
            if (pwr_hold) begin
                up_r <= up_r + 32'h1;
            end
            if (awoff_d_r && !ctrl_r[CTRL_AWOFF]) begin
                wait_r <= 32'(AWOFF_WAIT);
            end else if (wait_r != 32'h0) begin
                wait_r <= wait_r - 32'h1;
            end
            if (move_go && !busy) begin
                remain_r <= {1'b0, hwdata[30:0]};
                dir_r    <= hwdata[31];
                ph_cnt_r <= 32'h0;
            end else if (ph_cnt_r != 32'h0) begin
                ph_cnt_r <= ph_cnt_r - 32'h1;
            end else if (pulse_r) begin
                pulse_r  <= 1'b0;                                          // falling edge steps
                ph_cnt_r <= period_r;
            end else if (remain_r != 32'h0 && wait_r == 32'h0 && !pwr_hold) begin
                // Pulses still go out with windings off; the driver drops them
                pulse_r  <= 1'b1;
                remain_r <= remain_r - 32'h1;
                ph_cnt_r <= period_r;
            end
        end
    end

    // ----------------------------------------------------------------
    // Link drive
    // ----------------------------------------------------------------
    wire dual = ctrl_r[CTRL_DUAL];
    assign link.step_pulse_in = dual ? (pulse_r & ~dir_r) : pulse_r;
    assign link.dir_ccw_in    = dual ? (pulse_r & dir_r) : ~dir_r;
    assign link.awoff         = ctrl_r[CTRL_AWOFF];
    assign link.step_sel_b    = ctrl_r[CTRL_SEL_B];
    // A brake motor is kept free for as long as a move runs
    assign link.brake_release = ctrl_r[CTRL_BRK_REL] | (ctrl_r[CTRL_BRAKE_M] & busy);
endmodule
`default_nettype wire

/* step_link_assertions.sv */
// Concurrent checks on the stepping link and power stage
`timescale 1ns/1ps
`default_nettype none
module step_link_assertions
    import step_pkg::*;
(
    // Clock and reset
    input wire logic             hclk,
    input wire logic             hresetn,
    // Link
    input wire logic             step_pulse_in,
    input wire logic             dir_ccw_in,
    input wire logic             awoff,
    input wire logic             brake_release,
    input wire logic             excitation_home_flag,
    input wire logic             overheat_ok,
    // Driver side
    input wire logic [POS_W-1:0] excitation_pos,
    input wire logic             phase_current_on,
    input wire logic             brake_released,
    input wire logic             home_led,
    input wire logic             overheat_led,
    input wire logic             dual_pulse_mode,
    input wire logic             auto_current_off,
    input wire logic             brake_external,
    input wire logic             over_temp
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----
    // Stepping
    // ----
    // Current cut by a latched trip
    wire logic heat_cut = !overheat_ok && auto_current_off;
    sequence s_fall;
        !dual_pulse_mode && phase_current_on && $fell(step_pulse_in);
    endsequence
    sequence s_ccw_fall;
        dual_pulse_mode && phase_current_on && $fell(dir_ccw_in) && !$fell(step_pulse_in);
    endsequence
    sequence s_moved;
        ##[1:3] $changed(excitation_pos);
    endsequence
    AST_SINGLE_STEP: assert property (s_fall |-> s_moved)
        else $error("no step after pulse fall");
    AST_DUAL_STEP: assert property (s_ccw_fall |-> s_moved)
        else $error("no step after reverse pulse fall");
    AST_HOME_AT_ZERO: assert property (excitation_home_flag == (excitation_pos == POS_HOME))
        else $error("home flag not tied to position");
    AST_HOME_LED: assert property (home_led == excitation_home_flag)
        else $error("home lamp differs from flag");
    AST_POS_RANGE: assert property (excitation_pos < POS_CYCLE)
        else $error("position beyond one cycle");
    AST_CUT_HOLDS: assert property (!phase_current_on [*2] |=> $stable(excitation_pos))
        else $error("position moved with current cut");
    // ----
    // Current, brake, overheat
    // ----
    AST_AWOFF_CUTS: assert property (awoff |-> !phase_current_on)
        else $error("current on with windings off");
    AST_CURRENT_BACK: assert property ($fell(awoff) && !heat_cut |-> phase_current_on)
        else $error("current not restored");
    AST_BRAKE_EXT: assert property (brake_external && !heat_cut |-> brake_released == brake_release)
        else $error("brake not following release input");
    AST_OH_TRIP: assert property (over_temp |-> ##[0:3] !overheat_ok)
        else $error("overheat output not dropped");
    AST_OH_LED: assert property (overheat_led == !overheat_ok)
        else $error("overheat lamp wrong");
    AST_ACO_CUT: assert property (heat_cut |-> !phase_current_on && !brake_released)
        else $error("trip did not cut current and brake");
    AST_OH_LATCH: assert property (!overheat_ok |=> !overheat_ok)
        else $error("overheat cleared without reset");
endmodule
`default_nettype wire

/* stepper_driver_io_control_tb.sv */
// Self-checking bench: controller and driver joined over the link
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module stepper_driver_io_control_tb;
    import step_pkg::*;
    // ----
    // Signals and instances
    // ----
    logic             hclk, hresetn, hsel, hwrite, over_temp, dual, aco, brk_ext, sel, live;
    logic [31:0]      haddr, hwdata;
    logic [1:0]       htrans;
    logic [3:0]       dial_a, dial_b;
    wire logic [31:0] hrdata;
    wire logic        hreadyout, hresp, cur_on, brk_rel, home_led, oh_led;
    wire logic [11:0] pos;
    int               mismatches, samples_checked, k;
    logic [3:0]       dials [8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hf};
    step_link_if link();
    step_controller #(.AWOFF_WAIT(10), .PWRUP_WAIT(10), .BRAKE_WAIT(10)) i_step_controller (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .link(link));
    step_driver i_step_driver (
        .hclk(hclk), .hresetn(hresetn), .link(link), .step_angle_dial_a(dial_a), .step_angle_dial_b(dial_b),
        .dual_pulse_mode(dual), .auto_current_off(aco), .brake_external(brk_ext), .over_temp(over_temp),
        .phase_current_on(cur_on), .brake_released(brk_rel), .excitation_pos(pos), .home_led(home_led),
        .overheat_led(oh_led));
    step_link_assertions i_step_link_assertions (
        .hclk(hclk), .hresetn(hresetn), .step_pulse_in(link.step_pulse_in), .awoff(link.awoff),
        .dir_ccw_in(link.dir_ccw_in),
        .brake_release(link.brake_release), .excitation_home_flag(link.excitation_home_flag),
        .overheat_ok(link.overheat_ok), .excitation_pos(pos), .phase_current_on(cur_on),
        .brake_released(brk_rel), .home_led(home_led), .overheat_led(oh_led), .dual_pulse_mode(dual),
        .auto_current_off(aco), .brake_external(brk_ext), .over_temp(over_temp));
    // Clock
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // ----
    // Tasks
    // ----
    function automatic int stp(input logic [3:0] d);
        case (d)
            4'h0: return 250;
            4'h1: return 125;
            4'h2: return 100;
            4'h4: return 50;
            4'h6: return 25;
            4'h8: return 10;
            4'ha: return 5;
            default: return 1;
        endcase
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic give_up();
        mismatches++;
        complete_run();
    endtask
    task automatic edge_rdy();
        for (int i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1)
                return;
        end
        give_up();
    endtask
    // One single word transfer
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        edge_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        edge_rdy();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 400; i++) begin
            ahb(1'b0, REG_STATUS, 32'h0);
            if (hrdata[1:0] === 2'b00)
                return;
        end
        give_up();
    endtask
    task automatic look();
        int m;
        repeat (4) @(posedge hclk);
        @(negedge hclk);
        m = ((k % int'(POS_CYCLE)) + int'(POS_CYCLE)) % int'(POS_CYCLE);
        `CHK("pos", 12'(m), pos)
        `CHK("home", m == 0, link.excitation_home_flag)
        @(posedge hclk);
    endtask
    task automatic move(input int n, input logic ccw);
        ahb(1'b1, REG_MOVE, {ccw, 31'(n)});
        wait_idle();
        if (live)
            k += (ccw ? -n : n) * stp(sel ? dial_b : dial_a);
        look();
    endtask
    task automatic ctrl(input logic [3:0] v);
        sel = v[1];
        dual <= v[3];
        ahb(1'b1, REG_CTRL, {28'h0, v});
        repeat (2) @(posedge hclk);
    endtask
    task automatic heat(input logic hot);
        over_temp <= hot;
        repeat (5) @(posedge hclk);
        @(negedge hclk);
        `CHK("oh_ok", 1'b0, link.overheat_ok)
        `CHK("oh_led", 1'b1, oh_led)
        @(posedge hclk);
    endtask
    task automatic rst();
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        k = 0;
        sel = 1'b0;
        @(posedge hclk);
        `CHK("home0", 1'b1, link.excitation_home_flag)
        ahb(1'b0, REG_PERIOD, 32'h0);
        `CHK("period", PERIOD_RESET, hrdata)
        ahb(1'b1, REG_PERIOD, 32'h2);
        ahb(1'b0, REG_STATUS, 32'h0);
        `CHK("pwr_wait", 1'b1, hrdata[1])
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        {hsel, hwrite, over_temp, dual, aco, brk_ext, hresetn} = 7'h0;
        {haddr, hwdata, htrans, dial_a, dial_b} = '0;
        live = 1'b1;
        void'($urandom(83));
        rst();
        ahb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 32'h0, hrdata)
        $display("test reset done");
        move(5, 1'b0);
        move(5, 1'b0);
        move(3, 1'b0);
        move(3, 1'b1);
        ctrl(4'h8);
        move(4, 1'b1);
        move(6, 1'b1);
        ctrl(4'h0);
        $display("test modes done");
        dial_a <= 4'h6;
        move(9, 1'b0);
        dial_a <= 4'h0;
        move(10, 1'b0);
        dial_a <= 4'h6;
        move(9, 1'b1);
        dial_b <= 4'h6;
        dial_a <= 4'h0;
        ctrl(4'h2);
        `CHK("sel", 1'b1, link.step_sel_b)
        move(4, 1'b0);
        move(4, 1'b1);
        ctrl(4'h0);
        for (int i = 0; i < 6; i++) begin
            dial_a <= dials[$urandom % 8];
            move(1 + $urandom % 20, 1'($urandom));
        end
        $display("test steps done");
        ctrl(4'h1);
        `CHK("cur_off", 1'b0, cur_on)
        live = 1'b0;
        move(5, 1'b0);
        live = 1'b1;
        ctrl(4'h0);
        `CHK("cur_on", 1'b1, cur_on)
        ahb(1'b0, REG_STATUS, 32'h0);
        `CHK("awoff_wait", 1'b1, hrdata[1])
        wait_idle();
        brk_ext <= 1'b1;
        for (int b = 0; b < 2; b++) begin
            ctrl({1'b0, 1'(b), 2'b00});
            `CHK("brake", 1'(b), brk_rel)
        end
        $display("test current done");
        heat(1'b1);
        `CHK("cur_hot", 1'b1, cur_on)
        `CHK("brk_hot", 1'b1, brk_rel)
        move(3, 1'b0);
        heat(1'b0);
        rst();
        aco <= 1'b1;
        ctrl(4'h4);
        heat(1'b1);
        `CHK("cur_aco", 1'b0, cur_on)
        `CHK("brk_aco", 1'b0, brk_rel)
        live = 1'b0;
        move(2, 1'b0);
        heat(1'b0);
        rst();
        `CHK("oh_clear", 1'b1, link.overheat_ok)
        $display("test overheat done");
        complete_run();
    end
endmodule
`default_nettype wire
